// ==== common/rps_pkg.sv ====
// Package of constants for the reset pin sequencer
package rps_pkg;

  // Cycles the soft reset pin is driven low per pulse
  localparam int unsigned SOFT_DRIVE_CYCLES = 6;
  localparam int unsigned CNT_W = 3;
  // Synchroniser depth for pin inputs
  localparam int unsigned SYNC_STAGES = 2;
  // Cycles POR stays asserted after the synchronised hardware pin releases
  localparam int unsigned RELEASE_CYCLES = 2;

  typedef enum logic [3:0] {
    RPS_IDLE  = 4'b0001,
    RPS_DRIVE = 4'b0010,
    RPS_SENSE = 4'b0100,
    RPS_PULSE = 4'b1000
  } rps_soft_state_t;

endpackage

// ==== hw/rps_sync.sv ====
// Two flip-flop synchroniser for one reset pin level
`timescale 1ns/100ps
`default_nettype none
module rps_sync
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic async_i,
  output logic sync_o
);

  logic meta_ff;
  logic sync_ff;

  // Resets to the inactive (high) level of the pins
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
    end
    else
    begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule // rps_sync
`default_nettype wire

// ==== hw/rps_top.sv ====
// Reset pin sequencer: hardware reset pin and two-way soft reset pin
//
// Overview of operation
// - Hardware reset low holds all logic reset
// - Hardware reset release triggers POR, RTC spared
// - Soft pin low holds core domain reset
// - Soft pin release resets core, registers, peripherals
// - Soft reset spares POR-only, RTC, debug, JTAG
// - Sensed low soft pin is then driven low
// - Drive six cycles, resense, repeat until high
`timescale 1ns/100ps
`default_nettype none
module rps_top
#(
  parameter int unsigned DRIVE_CYCLES = rps_pkg::SOFT_DRIVE_CYCLES
)
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic hw_reset_in_n_i,
  input wire logic soft_reset_io_n_i,
  output logic soft_reset_io_n_o,
  output logic soft_reset_io_n_oe_n_o,
  output logic por_reset_n_o,
  output logic core_reset_n_o,
  output logic soft_reset_pulse_o,
  output logic run_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Both pins pass the same two-flop stage; index 0 is the hardware pin, 1 the soft pin.
  // Nothing reads the first flop of a stage, so a late pin edge cannot split a decision.
  localparam int unsigned N_PINS = 2;

  logic [N_PINS-1:0] pin_raw;
  logic [N_PINS-1:0] pin_sync;
  logic hw_sync;
  logic soft_sync;

  assign pin_raw = {soft_reset_io_n_i, hw_reset_in_n_i};

  for (genvar g = 0; g < N_PINS; g++)
  begin : g_pin_sync
    rps_sync u_sync
    (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .async_i(pin_raw[g]),
      .sync_o(pin_sync[g])
    );
  end

  assign hw_sync = pin_sync[0];
  assign soft_sync = pin_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Hardware reset pin: power-on reset of every domain but the RTC

  logic por_n_ff;
  logic [1:0] por_rel_ff;

  // A short stretch after release keeps the POR edge clean for downstream logic
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      por_rel_ff <= 2'h0;
      por_n_ff <= 1'b0;
    end
    else if (!hw_sync)
    begin
      por_rel_ff <= 2'h0;
      por_n_ff <= 1'b0;
    end
    else if (por_rel_ff != 2'(rps_pkg::RELEASE_CYCLES))
    begin
      por_rel_ff <= por_rel_ff + 2'h1;
      por_n_ff <= 1'b0;
    end
    else
    begin
      por_n_ff <= 1'b1;
    end
  end

  assign por_reset_n_o = por_n_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Soft reset pin sequencer

  rps_pkg::rps_soft_state_t state_ff;
  rps_pkg::rps_soft_state_t nxt_state;
  logic [rps_pkg::CNT_W-1:0] cnt_ff;
  logic oe_n_ff;
  logic pin_lvl_ff;
  logic core_n_ff;
  logic pulse_ff;
  logic run_ff;
  logic seq_clr;

  // A hardware reset also abandons a soft sequence in mid-drive and frees the pin,
  // so the board never sees the device hold the line through its own power-on reset
  assign seq_clr = !reset_n_i || !por_n_ff;

  // Core domain may run only with the sequencer idle and the pin released
  function automatic logic core_free
  (
    input var rps_pkg::rps_soft_state_t st,
    input var logic pin_n
  );
    core_free = (st == rps_pkg::RPS_IDLE) && pin_n;
  endfunction

  // True on the last count of a phase that lasts lim cycles from zero
  function automatic logic cnt_last
  (
    input var logic [rps_pkg::CNT_W-1:0] cnt,
    input var int unsigned lim
  );
    cnt_last = (cnt == rps_pkg::CNT_W'(lim - 1));
  endfunction

  // Drive and sense timing, in edges of the system clock:
  //   the pin sampled low reaches soft_sync two edges later, then the enable turns on
  //   the enable stays on for DRIVE_CYCLES edges, counted by cnt_ff from zero
  //   it stays off for SYNC_STAGES + 1 edges so the released level clears the synchroniser
  //   the pin is judged on the last of them: low drives again, high gives the pulse
  // A shorter slot would judge the pin on the level the device drove itself.
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      rps_pkg::RPS_IDLE:
        if (!soft_sync)
          nxt_state = rps_pkg::RPS_DRIVE;
      rps_pkg::RPS_DRIVE:
        if (cnt_last(cnt_ff, DRIVE_CYCLES))
          nxt_state = rps_pkg::RPS_SENSE;
      rps_pkg::RPS_SENSE:
        if (cnt_last(cnt_ff, rps_pkg::SYNC_STAGES + 1))
          nxt_state = soft_sync ? rps_pkg::RPS_PULSE : rps_pkg::RPS_DRIVE;
      rps_pkg::RPS_PULSE:
        nxt_state = rps_pkg::RPS_IDLE;
      default:
        nxt_state = rps_pkg::RPS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i || !por_n_ff)
      state_ff <= rps_pkg::RPS_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i || !por_n_ff || nxt_state != state_ff)
      cnt_ff <= '0;
    else
      cnt_ff <= cnt_ff + rps_pkg::CNT_W'(1);
  end

  // Pin driven low only in the drive state; released by tristate so pullup raises it.
  // The enable is a flop of its own, so no decode glitch can reach the pad.
  always_ff @(posedge ref_clk_i)
  begin
    if (seq_clr)
      oe_n_ff <= 1'b1;
    else
      oe_n_ff <= (nxt_state != rps_pkg::RPS_DRIVE);
  end

  assign soft_reset_io_n_oe_n_o = oe_n_ff;

  // Drive level is registered like every pad output; the pin is only ever pulled low
  always_ff @(posedge ref_clk_i)
  begin
    pin_lvl_ff <= 1'b0;
  end

  assign soft_reset_io_n_o = pin_lvl_ff;

  // Core domain reset: held through the whole sequence, released after the pulse.
  // Only the core domain sees it; POR-only, RTC and debug logic stay on por_n_ff.
  always_ff @(posedge ref_clk_i)
  begin
    if (seq_clr)
      core_n_ff <= 1'b0;
    else
      core_n_ff <= core_free(nxt_state, soft_sync);
  end

  assign core_reset_n_o = core_n_ff;

  // One-cycle pulse that resets core, registers and peripherals on release
  always_ff @(posedge ref_clk_i)
  begin
    if (seq_clr)
      pulse_ff <= 1'b0;
    else
      pulse_ff <= (nxt_state == rps_pkg::RPS_PULSE);
  end

  assign soft_reset_pulse_o = pulse_ff;

  // Execution permitted only when neither reset is active. Limitation: run_o lags
  // the pin by the synchroniser and one flop, so a new low stops code a little late.
  always_ff @(posedge ref_clk_i)
  begin
    if (seq_clr)
      run_ff <= 1'b0;
    else
      run_ff <= core_free(nxt_state, soft_sync);
  end

  assign run_o = run_ff;

endmodule // rps_top
`default_nettype wire

// ==== verif/rps_ext_src.sv ====
// Board reset source model pulling the soft reset line
`timescale 1ns/100ps
`default_nettype none
module rps_ext_src
(
  input wire logic pull_i,
  input wire logic oe_n_i,
  output logic pin_o
);
  // Open drain: once both parties release, the pull-up wins
  assign pin_o = !(pull_i || !oe_n_i);
endmodule // rps_ext_src
`default_nettype wire

// ==== verif/rps_top_sva.sv ====
// Port assertions for the reset pin sequencer
`timescale 1ns/100ps
`default_nettype none
module rps_top_sva
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic hw_reset_in_n_i,
  input wire logic soft_reset_io_n_i,
  input wire logic soft_reset_io_n_o,
  input wire logic soft_reset_io_n_oe_n_o,
  input wire logic por_reset_n_o,
  input wire logic core_reset_n_o,
  input wire logic soft_reset_pulse_o,
  input wire logic run_o
);
  wire hw = hw_reset_in_n_i;
  wire oe = soft_reset_io_n_oe_n_o;
  wire por = por_reset_n_o;
  wire core = core_reset_n_o;
  wire pls = soft_reset_pulse_o;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  a_hw_hold: assert property (!hw |-> ##3 !por) else $error("por late");
  a_hw_core: assert property (!por |=> !core && !run_o) else $error("core free");
  a_sync_lat: assert property ($fell(hw) && por |-> por[*3]) else $error("no sync");
  a_por_rel: assert property ($rose(por) |-> $past(hw, 4)) else $error("por early");
  a_run_up: assert property ($rose(por) |=> core && run_o) else $error("no run");
  a_soft_hold: assert property (!oe |-> !core && !run_o && por) else $error("hold");
  a_pin_core: assert property (!soft_reset_io_n_i |-> ##3 !core) else $error("core run");
  a_drive_len: assert property ($fell(oe) |-> !oe[*6] ##1 oe) else $error("drive");
  a_sense_gap: assert property ($rose(oe) |-> oe[*3]) else $error("sense slot");
  a_pulse_rel: assert property (pls |=> !pls && core && run_o) else $error("pulse");
  a_pulse_src: assert property (pls |-> !core && $past(oe, 3)) else $error("cause");
  a_drive_low: assert property (!soft_reset_io_n_o) else $error("drive high");
endmodule // rps_top_sva
bind rps_top rps_top_sva chk_i (.ref_clk_i, .reset_n_i, .hw_reset_in_n_i, .soft_reset_io_n_i,
  .soft_reset_io_n_o, .soft_reset_io_n_oe_n_o, .por_reset_n_o, .core_reset_n_o,
  .soft_reset_pulse_o, .run_o);
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the reset pin sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hw_n = 1'b1;
  logic src_low = 1'b0;
  logic pin, drv, oe_n, por_n, core_n, pulse, run;
  int n_fail = 0;
  int samples_checked = 0;
  bit hung = 1'b0;
  always #50 clk = ~clk;
  rps_ext_src src (.pull_i(src_low), .oe_n_i(oe_n), .pin_o(pin));
  rps_top dut (.ref_clk_i(clk), .reset_n_i(rst_n), .hw_reset_in_n_i(hw_n),
    .soft_reset_io_n_i(pin), .soft_reset_io_n_o(drv), .soft_reset_io_n_oe_n_o(oe_n),
    .por_reset_n_o(por_n), .core_reset_n_o(core_n), .soft_reset_pulse_o(pulse), .run_o(run));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s exp %0h got %0h", nm, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wait_run();
    int i;
    for (i = 0; i < 50 && run !== 1'b1; i++)
      @(negedge clk);
    chk("run", run, 8'h01);
    if (i == 50)
      hung = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_hw();
    hw_n = 1'b0;
    repeat (8) @(negedge clk);
    chk("por", por_n, 8'h00);
    chk("run", run, 8'h00);
    hw_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("por", por_n, 8'h00);
    @(negedge clk);
    chk("por", por_n, 8'h01);
    @(negedge clk);
    wait_run();
    chk("core", core_n, 8'h01);
  endtask
  // Source held h+1 cycles; a long hold must cost extra drive pulses
  task automatic t_soft(int h, int p);
    int k, n;
    n = 0;
    src_low = 1'b1;
    for (k = 0; k < 99 && pulse !== 1'b1; k++)
    begin
      @(negedge clk);
      n += int'(oe_n === 1'b0);
      if (k == h)
        src_low = 1'b0;
    end
    chk("pulse", pulse, 8'h01);
    if (k == 99)
      hung = 1'b1;
    chk("low", n[7:0], 8'(6 * p));
    chk("drv", drv, 8'h00);
    chk("por", por_n, 8'h01);
    chk("core", core_n, 8'h00);
    @(negedge clk);
    chk("core", core_n, 8'h01);
    chk("run", run, 8'h01);
  endtask
  initial
  begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    wait_run();
    if (!hung)
      t_hw();
    if (!hung)
      t_soft(2, 1);
    if (!hung)
      t_soft(14, 2);
    if (!hung)
      t_soft(25, 3);
    print_verdict();
  end
endmodule // tb
`default_nettype wire
